// [rtl/pdem_mux.sv]
// What this block does
// - Serial1 transmitter enabled forces pin D3 to output carrying transmit data.
// - Serial1 receiver enabled forces pin D2 to input feeding the receiver.
// - Forced-input D2 pull-up follows its port output bit, killed by global disable.
// - Two-wire enable takes pin D1 away from the port as data line.
// - Two-wire enable takes pin D0 away from the port as clock line.
// - Two-wire line inputs reject pulses shorter than 50 ns.
// - Two-wire lines only pull low, never drive high, slew limiting on.
// - Spike filters sit between pin input and two-wire logic only.
// - Pins D3..D0 serve as external interrupts; enabled interrupt keeps input on.
// - Direction bit E2 picks serial0 sync clock out (set) or in (clear).
// - Sync clock pin drive only while its serial port runs synchronous; the clock input is fed in every mode.
// - Clock-out fuse drives divided clock on E7 over port and direction bits.
// - Divided clock keeps driving E7 while reset is asserted.
// - Timer3 compare pins also carry its PWM waveform.
// - Pin E7 feeds timer3 capture, pin E6 feeds timer3 count clock.
// - Direction bit D5 picks serial1 sync clock out (set) or in (clear).
`timescale 1ns/100ps
module pdem_mux (
    input  wire logic       clk_sys_in,
    input  wire logic       rst_in,
    input  wire logic [7:0] portd_out_in,
    input  wire logic [7:0] portd_dir_in,
    input  wire logic [7:0] porte_out_in,
    input  wire logic [7:0] porte_dir_in,
    input  wire logic       global_pullup_disable_in,
    input  wire logic       sleep_input_disable_in,
    input  wire logic [7:0] portd_pad_in,
    input  wire logic [7:0] porte_pad_in,
    input  wire logic       serial1_tx_enable_in,
    input  wire logic       serial1_tx_data_in,
    input  wire logic       serial1_rx_enable_in,
    input  wire logic       serial1_sync_mode_in,
    input  wire logic       serial1_sync_clock_drive_in,
    input  wire logic       serial0_tx_enable_in,
    input  wire logic       serial0_tx_data_in,
    input  wire logic       serial0_sync_mode_in,
    input  wire logic       serial0_sync_clock_drive_in,
    input  wire logic       two_wire_enable_in,
    input  wire logic       twi_sda_pull_low_in,
    input  wire logic       twi_scl_pull_low_in,
    input  wire logic [7:0] ext_irq_enable_in,
    input  wire logic [2:0] timer3_compare_en_in,
    input  wire logic [2:0] timer3_compare_val_in,
    input  wire logic       clock_out_fuse_in,
    input  wire logic       divided_clock_in,
    output logic      [7:0] portd_pad_out,
    output logic      [7:0] portd_pad_oe_out,
    output logic      [7:0] portd_pullup_out,
    output logic      [7:0] portd_input_en_out,
    output logic      [7:0] porte_pad_out,
    output logic      [7:0] porte_pad_oe_out,
    output logic      [7:0] porte_pullup_out,
    output logic      [7:0] porte_input_en_out,
    output logic      [7:0] portd_pin_out,
    output logic      [7:0] porte_pin_out,
    output logic            serial1_rx_data_out,
    output logic            serial1_sync_clock_out,
    output logic            serial0_sync_clock_out,
    output logic            twi_sda_out,
    output logic            twi_scl_out,
    output logic            twi_slew_limit_out,
    output logic      [7:0] ext_irq_out,
    output logic            timer3_capture_out,
    output logic            timer3_count_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Attribute resolution: {pullup, dir, value, input enable}
    function automatic logic [31:0] pdem_resolve(
        input logic [7:0] pu_en, input logic [7:0] pu_vl,
        input logic [7:0] dd_en, input logic [7:0] dd_vl,
        input logic [7:0] pv_en, input logic [7:0] pv_vl,
        input logic [7:0] di_en, input logic [7:0] di_vl,
        input logic [7:0] dir, input logic [7:0] val,
        input logic pu_off, input logic sleep);
        logic [7:0] pu;
        logic [7:0] dd;
        logic [7:0] pv;
        logic [7:0] die;
        pu  = (pu_en & pu_vl) | (~pu_en & val & ~dir & {8{~pu_off}});
        dd  = (dd_en & dd_vl) | (~dd_en & dir);
        pv  = (pv_en & pv_vl) | (~pv_en & val);
        die = (di_en & di_vl) | (~di_en & {8{~sleep}});
        return {pu, dd, pv, die};
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [7:0] pd_s1_q;
    logic [7:0] pd_s2_q;
    logic [7:0] pe_s1_q;
    logic [7:0] pe_s2_q;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pd_s1_q <= pdem_pkg::VEC_RST;
            pd_s2_q <= pdem_pkg::VEC_RST;
            pe_s1_q <= pdem_pkg::VEC_RST;
            pe_s2_q <= pdem_pkg::VEC_RST;
        end else begin
            pd_s1_q <= portd_pad_in;
            pd_s2_q <= pd_s1_q;
            pe_s1_q <= porte_pad_in;
            pe_s2_q <= pe_s1_q;
        end
    end
    // Fuse strap, no reset so the clock path runs through reset
    logic fuse_s1_q;
    logic fuse_s2_q;
    always_ff @(posedge clk_sys_in) begin
        fuse_s1_q <= clock_out_fuse_in;
        fuse_s2_q <= fuse_s1_q;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Override vectors
    logic [7:0]  d_pu_en, d_pu_vl, d_dd_en, d_dd_vl, d_pv_en, d_pv_vl, d_di_en, d_di_vl;
    logic [7:0]  e_pu_en, e_pu_vl, e_dd_en, e_dd_vl, e_pv_en, e_pv_vl, e_di_en, e_di_vl;
    logic [31:0] d_res;
    logic [31:0] e_res;
    logic        sck1_drive;
    logic        sck0_drive;
    logic        pu_off;
    assign pu_off     = global_pullup_disable_in;
    assign sck1_drive = serial1_sync_mode_in & portd_dir_in[pdem_pkg::PD_XCK];
    assign sck0_drive = serial0_sync_mode_in & porte_dir_in[pdem_pkg::PE_SCK0];
    always_comb begin
        {d_pu_en, d_pu_vl, d_dd_en, d_dd_vl, d_pv_en, d_pv_vl, d_di_en, d_di_vl} = '0;
        // Transmit pin
        d_pu_en[pdem_pkg::PD_TXD] = serial1_tx_enable_in;
        d_dd_en[pdem_pkg::PD_TXD] = serial1_tx_enable_in;
        d_dd_vl[pdem_pkg::PD_TXD] = 1'h1;
        d_pv_en[pdem_pkg::PD_TXD] = serial1_tx_enable_in;
        d_pv_vl[pdem_pkg::PD_TXD] = serial1_tx_data_in;
        // Receive pin
        d_pu_en[pdem_pkg::PD_RXD] = serial1_rx_enable_in;
        d_dd_en[pdem_pkg::PD_RXD] = serial1_rx_enable_in;
        d_pu_vl[pdem_pkg::PD_RXD] = portd_out_in[pdem_pkg::PD_RXD] & ~pu_off;
        // Two-wire lines: pull low only
        d_pu_en[pdem_pkg::PD_SDA] = two_wire_enable_in;
        d_pu_vl[pdem_pkg::PD_SDA] = portd_out_in[pdem_pkg::PD_SDA] & ~pu_off;
        d_dd_en[pdem_pkg::PD_SDA] = two_wire_enable_in;
        d_dd_vl[pdem_pkg::PD_SDA] = twi_sda_pull_low_in;
        d_pv_en[pdem_pkg::PD_SDA] = two_wire_enable_in;
        d_pu_en[pdem_pkg::PD_SCL] = two_wire_enable_in;
        d_pu_vl[pdem_pkg::PD_SCL] = portd_out_in[pdem_pkg::PD_SCL] & ~pu_off;
        d_dd_en[pdem_pkg::PD_SCL] = two_wire_enable_in;
        d_dd_vl[pdem_pkg::PD_SCL] = twi_scl_pull_low_in;
        d_pv_en[pdem_pkg::PD_SCL] = two_wire_enable_in;
        // Interrupt inputs keep their input path
        d_di_en[3:0] = ext_irq_enable_in[3:0];
        d_di_vl[3:0] = 4'hF;
        // Serial1 sync clock
        d_dd_en[pdem_pkg::PD_XCK] = sck1_drive;
        d_dd_vl[pdem_pkg::PD_XCK] = 1'h1;
        d_pv_en[pdem_pkg::PD_XCK] = sck1_drive;
        d_pv_vl[pdem_pkg::PD_XCK] = serial1_sync_clock_drive_in;
        {e_pu_en, e_pu_vl, e_dd_en, e_dd_vl, e_pv_en, e_pv_vl} = '0;
        e_di_en = {ext_irq_enable_in[7:4], 4'h0};
        e_di_vl = 8'hF0;
        // Serial0 transmit
        e_pu_en[pdem_pkg::PE_TXD0] = serial0_tx_enable_in;
        e_dd_en[pdem_pkg::PE_TXD0] = serial0_tx_enable_in;
        e_dd_vl[pdem_pkg::PE_TXD0] = 1'h1;
        e_pv_en[pdem_pkg::PE_TXD0] = serial0_tx_enable_in;
        e_pv_vl[pdem_pkg::PE_TXD0] = serial0_tx_data_in;
        // Serial0 sync clock
        e_dd_en[pdem_pkg::PE_SCK0] = sck0_drive;
        e_dd_vl[pdem_pkg::PE_SCK0] = 1'h1;
        e_pv_en[pdem_pkg::PE_SCK0] = sck0_drive;
        e_pv_vl[pdem_pkg::PE_SCK0] = serial0_sync_clock_drive_in;
        // Timer3 compare and PWM; direction left to software
        e_pv_en[pdem_pkg::PE_OCC:pdem_pkg::PE_OCA] = timer3_compare_en_in;
        e_pv_vl[pdem_pkg::PE_OCC:pdem_pkg::PE_OCA] = timer3_compare_val_in;
    end
    assign d_res = pdem_resolve(d_pu_en, d_pu_vl, d_dd_en, d_dd_vl, d_pv_en, d_pv_vl,
                                d_di_en, d_di_vl, portd_dir_in, portd_out_in,
                                pu_off, sleep_input_disable_in);
    assign e_res = pdem_resolve(e_pu_en, e_pu_vl, e_dd_en, e_dd_vl, e_pv_en, e_pv_vl,
                                e_di_en, e_di_vl, porte_dir_in, porte_out_in,
                                pu_off, sleep_input_disable_in);

    ////////////////////////////////////////////////////////////////////////////
    // Pad drive registers
    logic [7:0] pd_out_q, pd_oe_q, pd_pu_q, pd_die_q;
    logic [6:0] pe_out_q, pe_oe_q;
    logic [7:0] pe_pu_q, pe_die_q;
    logic       pe7_out_q;
    logic       pe7_oe_q;
    logic       slew_q;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pd_pu_q  <= pdem_pkg::VEC_RST;
            pd_oe_q  <= pdem_pkg::VEC_RST;
            pd_out_q <= pdem_pkg::VEC_RST;
            pd_die_q <= pdem_pkg::VEC_RST;
            pe_pu_q  <= pdem_pkg::VEC_RST;
            pe_oe_q  <= pdem_pkg::VEC_RST[6:0];
            pe_out_q <= pdem_pkg::VEC_RST[6:0];
            pe_die_q <= pdem_pkg::VEC_RST;
            slew_q   <= pdem_pkg::BIT_RST;
        end else begin
            pd_pu_q  <= d_res[31:24];
            pd_oe_q  <= d_res[23:16];
            pd_out_q <= d_res[15:8];
            pd_die_q <= d_res[7:0];
            pe_pu_q  <= e_res[31:24] & ~{fuse_s2_q, 7'h00};
            pe_oe_q  <= e_res[22:16];
            pe_out_q <= e_res[14:8];
            pe_die_q <= e_res[7:0];
            slew_q   <= two_wire_enable_in;
        end
    end

    // Clock-out pin keeps running through reset when the fuse is set
    always_ff @(posedge clk_sys_in) begin
        if (fuse_s2_q) begin
            pe7_oe_q  <= 1'h1;
            pe7_out_q <= divided_clock_in;
        end else if (rst_in) begin
            pe7_oe_q  <= pdem_pkg::BIT_RST;
            pe7_out_q <= pdem_pkg::BIT_RST;
        end else begin
            pe7_oe_q  <= e_res[16 + pdem_pkg::PE_DCLK];
            pe7_out_q <= e_res[8 + pdem_pkg::PE_DCLK];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input side towards port and peripherals
    logic [7:0] pd_pin_q;
    logic [7:0] pe_pin_q;
    logic       rxd_q;
    logic       sck1_in_q;
    logic       sck0_in_q;
    logic [7:0] irq_q;
    logic       cap_q;
    logic       cnt_q;

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            pd_pin_q  <= pdem_pkg::VEC_RST;
            pe_pin_q  <= pdem_pkg::VEC_RST;
            rxd_q     <= pdem_pkg::LINE_RST;
            sck1_in_q <= pdem_pkg::BIT_RST;
            sck0_in_q <= pdem_pkg::BIT_RST;
            irq_q     <= pdem_pkg::VEC_RST;
            cap_q     <= pdem_pkg::BIT_RST;
            cnt_q     <= pdem_pkg::BIT_RST;
        end else begin
            pd_pin_q  <= pd_s2_q & d_res[7:0];
            pe_pin_q  <= pe_s2_q & e_res[7:0];
            rxd_q     <= serial1_rx_enable_in ? pd_s2_q[pdem_pkg::PD_RXD]
                                              : pdem_pkg::LINE_RST;
            sck1_in_q <= pd_s2_q[pdem_pkg::PD_XCK] & d_res[pdem_pkg::PD_XCK];
            sck0_in_q <= pe_s2_q[pdem_pkg::PE_SCK0] & e_res[pdem_pkg::PE_SCK0];
            irq_q     <= {pe_s2_q[7:4] & e_res[7:4], pd_s2_q[3:0] & d_res[3:0]};
            cap_q     <= pe_s2_q[pdem_pkg::PE_DCLK] & e_res[pdem_pkg::PE_DCLK];
            cnt_q     <= pe_s2_q[pdem_pkg::PE_TCNT] & e_res[pdem_pkg::PE_TCNT];
        end
    end

    // Two-wire filters read the raw synchronised line, not the port path
    pdem_spike_filter u_sda_filt (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .line_in    (pd_s2_q[pdem_pkg::PD_SDA]),
        .line_out   (twi_sda_out)
    );

    pdem_spike_filter u_scl_filt (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .line_in    (pd_s2_q[pdem_pkg::PD_SCL]),
        .line_out   (twi_scl_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output assignments
    assign portd_pad_out          = pd_out_q;
    assign portd_pad_oe_out       = pd_oe_q;
    assign portd_pullup_out       = pd_pu_q;
    assign portd_input_en_out     = pd_die_q;
    assign porte_pad_out          = {pe7_out_q, pe_out_q};
    assign porte_pad_oe_out       = {pe7_oe_q, pe_oe_q};
    assign porte_pullup_out       = pe_pu_q;
    assign porte_input_en_out     = pe_die_q;
    assign portd_pin_out          = pd_pin_q;
    assign porte_pin_out          = pe_pin_q;
    assign serial1_rx_data_out    = rxd_q;
    assign serial1_sync_clock_out = sck1_in_q;
    assign serial0_sync_clock_out = sck0_in_q;
    assign twi_slew_limit_out     = slew_q;
    assign ext_irq_out            = irq_q;
    assign timer3_capture_out     = cap_q;
    assign timer3_count_out       = cnt_q;

endmodule // pdem_mux

// [rtl/pdem_pkg.sv]
package pdem_pkg;

    // Timing
    localparam int         CLK_PERIOD_NS = 10;
    localparam int         SPIKE_NS      = 50;
    localparam int         SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] SPIKE_CNT     = 3'(SPIKE_CYC);

    // Port D bit positions
    localparam int PD_SCL  = 0;
    localparam int PD_SDA  = 1;
    localparam int PD_RXD  = 2;
    localparam int PD_TXD  = 3;
    localparam int PD_XCK  = 5;

    // Port E bit positions
    localparam int PE_TXD0 = 1;
    localparam int PE_SCK0 = 2;
    localparam int PE_OCA  = 3;
    localparam int PE_OCB  = 4;
    localparam int PE_OCC  = 5;
    localparam int PE_TCNT = 6;
    localparam int PE_DCLK = 7;

    // Reset values
    localparam logic [7:0] VEC_RST  = 8'h00;
    localparam logic       LINE_RST = 1'h1;
    localparam logic       BIT_RST  = 1'h0;

endpackage

// [rtl/pdem_spike_filter.sv]
`timescale 1ns/100ps
module pdem_spike_filter (
    input  wire logic clk_sys_in,
    input  wire logic rst_in,
    input  wire logic line_in,
    output logic      line_out
);
    logic [2:0] cnt_q;
    logic       line_q;

    // Output moves only after the input has differed for the full window
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q  <= 3'h0;
            line_q <= pdem_pkg::LINE_RST;
        end else if (line_in == line_q) begin
            cnt_q <= 3'h0;
        end else if (cnt_q == pdem_pkg::SPIKE_CNT - 3'h1) begin
            cnt_q  <= 3'h0;
            line_q <= line_in;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end

    assign line_out = line_q;
endmodule // pdem_spike_filter

// [tb/pdem_mux_sva.sv]
`timescale 1ns/100ps
module pdem_mux_sva (
    input wire logic       clk_sys_in,
    input wire logic       rst_in,
    input wire logic [7:0] portd_out_in,
    input wire logic [7:0] porte_out_in,
    input wire logic [7:0] porte_dir_in,
    input wire logic       global_pullup_disable_in,
    input wire logic       sleep_input_disable_in,
    input wire logic [7:0] portd_pad_in,
    input wire logic       serial1_tx_enable_in,
    input wire logic       serial1_tx_data_in,
    input wire logic       serial1_rx_enable_in,
    input wire logic       serial0_sync_mode_in,
    input wire logic       serial0_sync_clock_drive_in,
    input wire logic       two_wire_enable_in,
    input wire logic       twi_sda_pull_low_in,
    input wire logic       twi_scl_pull_low_in,
    input wire logic [7:0] ext_irq_enable_in,
    input wire logic [2:0] timer3_compare_en_in,
    input wire logic [2:0] timer3_compare_val_in,
    input wire logic       clock_out_fuse_in,
    input wire logic       divided_clock_in,
    input wire logic [7:0] portd_pad_out,
    input wire logic [7:0] portd_pad_oe_out,
    input wire logic [7:0] portd_pullup_out,
    input wire logic [7:0] portd_input_en_out,
    input wire logic [7:0] porte_pad_out,
    input wire logic [7:0] porte_pad_oe_out,
    input wire logic       twi_sda_out,
    input wire logic       twi_slew_limit_out
);
    logic       live_q;
    logic [7:0] sda_hist_q;
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) live_q <= 1'b0;
        else live_q <= 1'b1;
    end
    always_ff @(posedge clk_sys_in) sda_hist_q <= {sda_hist_q[6:0], portd_pad_in[1]};
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    sequence s_fuse_on;
        clock_out_fuse_in [*4];
    endsequence
    a_tx_drive_pin: assert property (
        live_q && $past(serial1_tx_enable_in) |-> portd_pad_oe_out[3] && !portd_pullup_out[3]
        && portd_pad_out[3] == $past(serial1_tx_data_in)) else $error("tx pin wrong");
    a_rx_force_in: assert property (
        live_q && $past(serial1_rx_enable_in) |-> !portd_pad_oe_out[2] && portd_pullup_out[2]
        == ($past(portd_out_in[2]) && !$past(global_pullup_disable_in))) else $error("rx pin wrong");
    a_twi_open_drain: assert property (
        live_q && $past(two_wire_enable_in) |-> portd_pad_out[1:0] == 2'h0 && twi_slew_limit_out
        && portd_pad_oe_out[1:0] == {$past(twi_sda_pull_low_in), $past(twi_scl_pull_low_in)})
        else $error("two-wire drive wrong");
    a_spike_reject: assert property (
        live_q && $changed(twi_sda_out) |-> sda_hist_q[5:2] == {4{twi_sda_out}})
        else $error("short pulse passed");
    a_irq_input_en: assert property (
        live_q |-> portd_input_en_out[3:0] == ($past(ext_irq_enable_in[3:0])
        | {4{!$past(sleep_input_disable_in)}})) else $error("input enable wrong");
    a_sync_clk_pin: assert property (
        live_q |-> porte_pad_oe_out[2] == $past(porte_dir_in[2]) && porte_pad_out[2] ==
        (($past(serial0_sync_mode_in) && $past(porte_dir_in[2])) ?
        $past(serial0_sync_clock_drive_in) : $past(porte_out_in[2]))) else $error("clock pin wrong");
    a_compare_pins: assert property (
        live_q |-> porte_pad_oe_out[5:3] == $past(porte_dir_in[5:3]) && porte_pad_out[5:3] ==
        (($past(timer3_compare_en_in) & $past(timer3_compare_val_in))
        | (~$past(timer3_compare_en_in) & $past(porte_out_in[5:3])))) else $error("compare pin wrong");
    a_fuse_clk_out: assert property (@(posedge clk_sys_in) disable iff (1'b0)
        s_fuse_on |-> porte_pad_oe_out[7] && porte_pad_out[7] == $past(divided_clock_in))
        else $error("divided clock not driven");
endmodule // pdem_mux_sva
bind pdem_mux pdem_mux_sva chk_u (.*);

// [tb/pdem_pad_model.sv]
`timescale 1ns/100ps
module pdem_pad_model (
    input wire logic       clk_sys_in,
    input wire logic [7:0] pad_out_in,
    input wire logic [7:0] oe_in,
    input wire logic [7:0] pullup_in,
    input wire logic [7:0] ext_en_in,
    input wire logic [7:0] ext_val_in,
    input wire logic [7:0] bus_pull_in,
    output logic     [7:0] level_out
);
    logic [7:0] last_q = 8'h00;
    always @(posedge clk_sys_in) last_q <= level_out;
    // Floating pins toggle; bus lines rest high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level_out[i] = oe_in[i] ? pad_out_in[i] : ext_en_in[i] ? ext_val_in[i] :
                (pullup_in[i] | bus_pull_in[i]) ? 1'b1 : ~last_q[i];
        end
    end
endmodule // pdem_pad_model

// [tb/tb_pdem_mux.sv]
`timescale 1ns/100ps
module tb_pdem_mux;
    logic clk_sys_in = 0, rst_in = 1;
    logic [7:0] portd_out_in, portd_dir_in, porte_out_in, porte_dir_in, ext_irq_enable_in;
    logic [7:0] portd_pad_in, porte_pad_in, d_en, d_val, e_en, e_val;
    logic global_pullup_disable_in, sleep_input_disable_in, serial1_tx_enable_in;
    logic serial1_tx_data_in, serial1_rx_enable_in, serial1_sync_mode_in;
    logic serial1_sync_clock_drive_in, serial0_tx_enable_in, serial0_tx_data_in;
    logic serial0_sync_mode_in, serial0_sync_clock_drive_in, two_wire_enable_in;
    logic twi_sda_pull_low_in, twi_scl_pull_low_in, clock_out_fuse_in, divided_clock_in = 0;
    logic [2:0] timer3_compare_en_in, timer3_compare_val_in;
    logic [7:0] portd_pad_out, portd_pad_oe_out, portd_pullup_out, portd_input_en_out;
    logic [7:0] porte_pad_out, porte_pad_oe_out, porte_pullup_out, porte_input_en_out;
    logic [7:0] portd_pin_out, porte_pin_out, ext_irq_out;
    logic serial1_rx_data_out, serial1_sync_clock_out, serial0_sync_clock_out, twi_sda_out;
    logic twi_scl_out, twi_slew_limit_out, timer3_capture_out, timer3_count_out;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    pdem_mux dut_u (.*);
    pdem_pad_model pad_d_u (.clk_sys_in(clk_sys_in), .pad_out_in(portd_pad_out),
        .oe_in(portd_pad_oe_out), .pullup_in(portd_pullup_out), .ext_en_in(d_en),
        .ext_val_in(d_val), .bus_pull_in(8'h03), .level_out(portd_pad_in));
    pdem_pad_model pad_e_u (.clk_sys_in(clk_sys_in), .pad_out_in(porte_pad_out),
        .oe_in(porte_pad_oe_out), .pullup_in(porte_pullup_out), .ext_en_in(e_en),
        .ext_val_in(e_val), .bus_pull_in(8'h00), .level_out(porte_pad_in));
    ////////////////////////////////////////////////////////////
    initial forever #5 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) divided_clock_in <= ~divided_clock_in;
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        {portd_out_in, portd_dir_in, porte_out_in, porte_dir_in, ext_irq_enable_in, d_val,
         e_val, global_pullup_disable_in, sleep_input_disable_in, serial1_tx_enable_in,
         serial1_tx_data_in, serial1_rx_enable_in, serial1_sync_mode_in, serial0_tx_data_in,
         serial1_sync_clock_drive_in, serial0_tx_enable_in, serial0_sync_mode_in,
         serial0_sync_clock_drive_in, two_wire_enable_in, twi_sda_pull_low_in,
         twi_scl_pull_low_in, timer3_compare_en_in,
         timer3_compare_val_in} = '0;
        d_en = 8'hFC;
        e_en = 8'hFF;
        clock_out_fuse_in = 1;
        tick(8);
        chk("dclk_oe_rst", 8'h80, porte_pad_oe_out & 8'h80);
        tick(8);
        rst_in = 0;
        portd_out_in = 8'h5A;
        portd_dir_in = 8'hF0;
        tick(2);
        chk("d_oe", 8'hF0, portd_pad_oe_out);
        chk("d_pu", 8'h0A, portd_pullup_out);
        chk("d_out", 8'h5A, portd_pad_out);
        chk("dclk_oe", 8'h80, porte_pad_oe_out & 8'h80);
        global_pullup_disable_in = 1;
        tick(1);
        chk("d_pu_off", 8'h00, portd_pullup_out);
        global_pullup_disable_in = 0;
        serial1_tx_enable_in = 1;
        tick(1);
        chk("tx_oe", 8'hF8, portd_pad_oe_out);
        chk("tx_pu", 8'h02, portd_pullup_out);
        chk("tx_out", 8'h52, portd_pad_out);
        serial1_tx_data_in = 1;
        tick(1);
        chk("tx_out1", 8'h5A, portd_pad_out);
        serial1_tx_enable_in = 0;
        portd_out_in = 8'h5E;
        portd_dir_in = 8'hFF;
        serial1_rx_enable_in = 1;
        tick(1);
        chk("rx_oe", 8'hFB, portd_pad_oe_out);
        chk("rx_pu", 8'h04, portd_pullup_out);
        global_pullup_disable_in = 1;
        tick(1);
        chk("rx_pu_off", 8'h00, portd_pullup_out);
        global_pullup_disable_in = 0;
        for (int v = 0; v < 2; v++) begin
            d_val[2] = v[0];
            tick(4);
            chk("rx_data", {7'h00, v[0]}, {7'h00, serial1_rx_data_out});
        end
        serial1_rx_enable_in = 0;
        portd_out_in = 8'h03;
        portd_dir_in = 8'h00;
        two_wire_enable_in = 1;
        twi_sda_pull_low_in = 1;
        tick(2);
        chk("tw_oe", 8'h02, portd_pad_oe_out & 8'h03);
        chk("tw_out", 8'h00, portd_pad_out & 8'h03);
        chk("tw_pu", 8'h03, portd_pullup_out & 8'h03);
        chk("tw_slew", 8'h01, {7'h00, twi_slew_limit_out});
        tick(10);
        chk("sda_low", 8'h00, {7'h00, twi_sda_out});
        twi_sda_pull_low_in = 0;
        tick(12);
        chk("sda_high", 8'h01, {7'h00, twi_sda_out});
        twi_sda_pull_low_in = 1;
        tick(4);
        chk("pin_spike", 8'h00, portd_pin_out & 8'h02);
        twi_sda_pull_low_in = 0;
        tick(10);
        chk("sda_spike", 8'h01, {7'h00, twi_sda_out});
        chk("scl_idle", 8'h01, {7'h00, twi_scl_out});
        two_wire_enable_in = 0;
        sleep_input_disable_in = 1;
        ext_irq_enable_in = 8'h35;
        tick(1);
        chk("d_ie", 8'h05, portd_input_en_out);
        chk("e_ie", 8'h30, porte_input_en_out);
        sleep_input_disable_in = 0;
        ext_irq_enable_in = 8'h00;
        tick(1);
        chk("d_ie_on", 8'hFF, portd_input_en_out);
        chk("irq_in", 8'h07, ext_irq_out & 8'h0F);
        portd_out_in = 8'h00;
        serial0_sync_clock_drive_in = 1;
        serial1_sync_clock_drive_in = 1;
        for (int i = 0; i < 4; i++) begin
            serial0_sync_mode_in = i[1];
            serial1_sync_mode_in = i[1];
            porte_dir_in = {5'h00, i[0], 2'h0};
            portd_dir_in = {2'h0, i[0], 5'h00};
            tick(1);
            chk("e2_oe", i[0] ? 8'h04 : 8'h00, porte_pad_oe_out & 8'h04);
            chk("e2_out", (i == 3) ? 8'h04 : 8'h00, porte_pad_out & 8'h04);
            chk("d5_out", (i == 3) ? 8'h20 : 8'h00, portd_pad_out & 8'h20);
        end
        porte_dir_in = 8'h38;
        timer3_compare_en_in = 3'h5;
        timer3_compare_val_in = 3'h7;
        tick(1);
        chk("oc_out", 8'h28, porte_pad_out & 8'h38);
        chk("oc_oe", 8'h38, porte_pad_oe_out & 8'h38);
        clock_out_fuse_in = 0;
        for (int v = 0; v < 2; v++) begin
            e_val = v[0] ? 8'h40 : 8'h80;
            tick(8);
            chk("tmr3_in", v[0] ? 8'h01 : 8'h02, {6'h00, timer3_capture_out, timer3_count_out});
        end
        end_of_test();
    end
endmodule // tb_pdem_mux
